// >>> rtl/spsc_device.sv
`timescale 1ns/1ps
module spsc_device (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Link to host
   spsc_if.device link,
   // Status
   output spsc_pkg::spsc_power_state_t power_state_o,
   output logic internal_reset_n_o,
   output logic [1:0] host_pull_o,
   output logic [1:0] audio_pull_o
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Three stages; second and third must agree before a change counts
   logic [2:0] sd_sync, slow_sync, io_sync, core_sync;
   logic sd_lvl, slow_lvl, io_lvl, core_lvl;
   logic next_sd_lvl, next_slow_lvl, next_io_lvl, next_core_lvl;
   logic sd_pin;
   // Floating input reads low: shutdown is the safe default
   assign sd_pin = link.shutdown_request_low_oe_n ? 1'b0 : link.shutdown_request_low;

   always_comb
   begin
      next_sd_lvl = (sd_sync[1] == sd_sync[2]) ? sd_sync[2] : sd_lvl;
      next_slow_lvl = (slow_sync[1] == slow_sync[2]) ? slow_sync[2] : slow_lvl;
      next_io_lvl = (io_sync[1] == io_sync[2]) ? io_sync[2] : io_lvl;
      next_core_lvl = (core_sync[1] == core_sync[2]) ? core_sync[2] : core_lvl;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sd_sync <= 3'h0;
         slow_sync <= 3'h0;
         io_sync <= 3'h0;
         core_sync <= 3'h0;
         sd_lvl <= 1'b0;
         slow_lvl <= 1'b0;
         io_lvl <= 1'b0;
         core_lvl <= 1'b0;
      end
      else
      begin
         sd_sync <= {sd_sync[1:0], sd_pin};
         slow_sync <= {slow_sync[1:0], link.slow_clk};
         io_sync <= {io_sync[1:0], link.io_supply_ok};
         core_sync <= {core_sync[1:0], link.core_supply_ok};
         sd_lvl <= next_sd_lvl;
         slow_lvl <= next_slow_lvl;
         io_lvl <= next_io_lvl;
         core_lvl <= next_core_lvl;
      end
   end

   // ----------------------------------------
   // Power state and sequencing
   // ----------------------------------------
   typedef enum logic [1:0] {SPSC_SQ_RESET, SPSC_SQ_WAIT_EDGE, SPSC_SQ_BOOT, SPSC_SQ_READY} spsc_seq_t;
   spsc_seq_t seq, next_seq;
   spsc_pkg::spsc_power_state_t next_power_state;
   logic slow_prev, next_slow_prev;
   logic next_internal_reset_n;
   logic [6:0] slow_cnt, next_slow_cnt;
   logic slow_rise;

   assign slow_rise = slow_lvl & ~slow_prev;

   always_comb
   begin
      next_slow_prev = slow_lvl;
      next_seq = seq;
      next_slow_cnt = slow_cnt;
      next_internal_reset_n = internal_reset_n_o;
      if (!io_lvl || !core_lvl)
         next_power_state = sd_lvl ? spsc_pkg::SPSC_PS_NOT_ALLOWED : spsc_pkg::SPSC_PS_SHUTDOWN;
      else
         next_power_state = sd_lvl ? spsc_pkg::SPSC_PS_ACTIVE : spsc_pkg::SPSC_PS_SHUTDOWN;
      if (next_power_state != spsc_pkg::SPSC_PS_ACTIVE)
      begin
         // Any lapse of supply or shutdown restarts the whole sequence
         next_seq = SPSC_SQ_RESET;
         next_slow_cnt = 7'h0;
         next_internal_reset_n = 1'b0;
      end
      else
      begin
         case (seq)
            SPSC_SQ_RESET:
               next_seq = SPSC_SQ_WAIT_EDGE;
            SPSC_SQ_WAIT_EDGE:
               if (slow_rise)
               begin
                  // Reset lifts on a slow-clock edge, never mid-period
                  next_internal_reset_n = 1'b1;
                  next_seq = SPSC_SQ_BOOT;
               end
            SPSC_SQ_BOOT:
               if (slow_rise)
               begin
                  // Wait out the slow clock settling window before ready
                  if (slow_cnt == 7'(spsc_pkg::SLOW_STABLE_CYCLES - 1))
                     next_seq = SPSC_SQ_READY;
                  else
                     next_slow_cnt = slow_cnt + 7'h1;
               end
            SPSC_SQ_READY:
               next_seq = SPSC_SQ_READY;
            default:
               next_seq = SPSC_SQ_RESET;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         seq <= SPSC_SQ_RESET;
         power_state_o <= spsc_pkg::SPSC_PS_SHUTDOWN;
         slow_prev <= 1'b0;
         slow_cnt <= 7'h0;
         internal_reset_n_o <= 1'b0;
      end
      else
      begin
         seq <= next_seq;
         power_state_o <= next_power_state;
         slow_prev <= next_slow_prev;
         slow_cnt <= next_slow_cnt;
         internal_reset_n_o <= next_internal_reset_n;
      end
   end

   // ----------------------------------------
   // Pin states
   // ----------------------------------------
   logic next_pins_oe_n, pins_oe_n;
   logic next_rts, rts;
   logic [1:0] next_host_pull, next_audio_pull;

   always_comb
   begin
      next_pins_oe_n = !((next_seq != SPSC_SQ_RESET) && (next_power_state == spsc_pkg::SPSC_PS_ACTIVE));
      next_rts = (next_seq != SPSC_SQ_READY);
      next_host_pull = spsc_pkg::PULL_UP;
      next_audio_pull = spsc_pkg::PULL_DOWN;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pins_oe_n <= 1'b1;
         rts <= 1'b1;
         host_pull_o <= spsc_pkg::PULL_UP;
         audio_pull_o <= spsc_pkg::PULL_DOWN;
      end
      else
      begin
         pins_oe_n <= next_pins_oe_n;
         rts <= next_rts;
         host_pull_o <= next_host_pull;
         audio_pull_o <= next_audio_pull;
      end
   end

   // Active: tx driven high throughout, rts driven high until ready; audio out stays Hi-Z
   assign link.host_serial_tx_pin = 1'b1;
   // Enables come straight from a flop so no decode glitch reaches a pin
   assign link.host_serial_tx_pin_oe_n = pins_oe_n;
   assign link.host_request_to_send_pin = rts;
   assign link.host_request_to_send_pin_oe_n = pins_oe_n;
   assign link.audio_data_out_pin = 1'b0;
   assign link.audio_data_out_pin_oe_n = 1'b1;
   assign link.debug_transmit_pin = 1'b0;
   assign link.debug_transmit_pin_oe_n = pins_oe_n;
endmodule

// >>> rtl/spsc_host.sv
`timescale 1ns/1ps
module spsc_host (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // User side
   input wire logic power_on_i,
   input wire logic reset_req_i,
   output logic ready_o,
   // Link to device
   spsc_if.host link
);
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   typedef enum logic [1:0] {SPSC_HS_OFF, SPSC_HS_HOLD, SPSC_HS_RUN} spsc_host_t;
   spsc_host_t st, next_st;
   logic [spsc_pkg::CNT_W-1:0] cnt, next_cnt;
   logic [spsc_pkg::CNT_W-1:0] sclk_cnt, next_sclk_cnt;
   logic sclk, next_sclk, supplies, next_supplies, sd, next_sd;
   logic next_ready;
   logic [2:0] rts_sync;

   always_comb
   begin
      next_st = st;
      next_cnt = cnt;
      next_supplies = power_on_i;
      next_sd = 1'b0;
      // Free-running slow clock, about 32.768 kHz
      next_sclk = sclk;
      next_sclk_cnt = sclk_cnt + 1'b1;
      if (sclk_cnt == spsc_pkg::CNT_W'(spsc_pkg::SLOW_HALF_CYC - 1))
      begin
         next_sclk_cnt = '0;
         next_sclk = ~sclk;
      end
      case (st)
         SPSC_HS_OFF:
         begin
            next_cnt = '0;
            if (power_on_i && supplies)
               next_st = SPSC_HS_HOLD;
         end
         SPSC_HS_HOLD:
         begin
            // Full minimum low time, then release only with supplies up
            if (!power_on_i)
               next_st = SPSC_HS_OFF;
            else if (cnt >= spsc_pkg::CNT_W'(spsc_pkg::SHUTDOWN_LOW_MIN_CYC - 1))
               next_st = SPSC_HS_RUN;
            else
               next_cnt = cnt + 1'b1;
         end
         SPSC_HS_RUN:
         begin
            next_sd = 1'b1;
            if (!power_on_i || reset_req_i)
            begin
               next_sd = 1'b0;
               next_cnt = '0;
               next_st = power_on_i ? SPSC_HS_HOLD : SPSC_HS_OFF;
            end
         end
         default:
            next_st = SPSC_HS_OFF;
      endcase
      next_ready = (st == SPSC_HS_RUN) && (rts_sync[2:1] == 2'b00);
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st <= SPSC_HS_OFF;
         cnt <= '0;
         sclk_cnt <= '0;
         sclk <= 1'b0;
         supplies <= 1'b0;
         sd <= 1'b0;
         ready_o <= 1'b0;
         rts_sync <= 3'h7;
      end
      else
      begin
         st <= next_st;
         cnt <= next_cnt;
         sclk_cnt <= next_sclk_cnt;
         sclk <= next_sclk;
         supplies <= next_supplies;
         sd <= next_sd;
         ready_o <= next_ready;
         rts_sync <= {rts_sync[1:0], link.host_request_to_send_pin};
      end
   end

   assign link.shutdown_request_low = sd;
   assign link.shutdown_request_low_oe_n = 1'b0;
   assign link.slow_clk = sclk;
   assign link.io_supply_ok = supplies;
   assign link.core_supply_ok = supplies;
   assign link.host_serial_rx_pin = 1'b1;
   assign link.host_clear_to_send_pin = 1'b0;
   assign link.audio_bit_clock_pin = 1'b0;
   assign link.audio_frame_sync_pin = 1'b0;
   assign link.audio_data_in_pin = 1'b0;
endmodule

// >>> rtl/spsc_if.sv
`timescale 1ns/1ps
interface spsc_if;
   logic shutdown_request_low;
   logic shutdown_request_low_oe_n;
   logic slow_clk;
   logic io_supply_ok;
   logic core_supply_ok;
   logic host_serial_tx_pin;
   logic host_serial_tx_pin_oe_n;
   logic host_request_to_send_pin;
   logic host_request_to_send_pin_oe_n;
   logic audio_data_out_pin;
   logic audio_data_out_pin_oe_n;
   logic debug_transmit_pin;
   logic debug_transmit_pin_oe_n;
   logic host_serial_rx_pin;
   logic host_clear_to_send_pin;
   logic audio_bit_clock_pin;
   logic audio_frame_sync_pin;
   logic audio_data_in_pin;
   modport device (
      input shutdown_request_low, shutdown_request_low_oe_n, slow_clk, io_supply_ok, core_supply_ok,
      output host_serial_tx_pin, host_serial_tx_pin_oe_n, host_request_to_send_pin,
      output host_request_to_send_pin_oe_n, audio_data_out_pin, audio_data_out_pin_oe_n,
      output debug_transmit_pin, debug_transmit_pin_oe_n,
      input host_serial_rx_pin, host_clear_to_send_pin, audio_bit_clock_pin,
      input audio_frame_sync_pin, audio_data_in_pin
   );
   modport host (
      output shutdown_request_low, shutdown_request_low_oe_n, slow_clk, io_supply_ok, core_supply_ok,
      input host_serial_tx_pin, host_serial_tx_pin_oe_n, host_request_to_send_pin,
      input host_request_to_send_pin_oe_n, audio_data_out_pin, audio_data_out_pin_oe_n,
      input debug_transmit_pin, debug_transmit_pin_oe_n,
      output host_serial_rx_pin, host_clear_to_send_pin, audio_bit_clock_pin,
      output audio_frame_sync_pin, audio_data_in_pin
   );
endinterface

// >>> rtl/spsc_pkg.sv
package spsc_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam longint SHUTDOWN_LOW_MIN_US = 5000;
   localparam longint READY_MAX_US = 100000;
   localparam longint SLOW_STABLE_MAX_US = 2000;
   localparam longint FAST_STABLE_MAX_US = 20000;
   localparam int SLOW_STABLE_CYCLES = 64;
   localparam longint SLOW_HALF_PERIOD_NS = 15259;
   localparam longint SHUTDOWN_LOW_MIN_CYC = (SHUTDOWN_LOW_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam longint SLOW_HALF_CYC = (SLOW_HALF_PERIOD_NS * 1000) / CLK_PERIOD_PS;
   localparam longint READY_MAX_CYC = (READY_MAX_US * 1000000) / CLK_PERIOD_PS;
   localparam int CNT_W = 32;
   // ----------------------------------------
   // Pull codes and power states
   // ----------------------------------------
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_UP = 2'h1;
   localparam logic [1:0] PULL_DOWN = 2'h2;
   typedef enum logic [1:0] {
      SPSC_PS_SHUTDOWN,
      SPSC_PS_ACTIVE,
      SPSC_PS_NOT_ALLOWED
   } spsc_power_state_t;
endpackage

// >>> testbench/shutdown_power_state_control_tb_top.sv
`timescale 1ns/1ps
module shutdown_power_state_control_tb_top;
   logic mclk_i;
   logic reset_n_i;
   logic power_on;
   logic reset_req;
   logic ready;
   spsc_pkg::spsc_power_state_t ps;
   spsc_pkg::spsc_power_state_t ps_b;
   spsc_pkg::spsc_power_state_t exp_ps;
   logic irst_n;
   logic irst_b;
   logic [1:0] host_pull;
   logic [1:0] audio_pull;
   logic [3:0] v;
   int failures;
   int compares;
   int cycles;
   int seed;
   int t0;
   int n0;
   int sdiv;
   int srise;
   spsc_if lnk();
   spsc_if lnk_b();
   spsc_device i_spsc_device (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(lnk), .power_state_o(ps),
      .internal_reset_n_o(irst_n), .host_pull_o(host_pull), .audio_pull_o(audio_pull));
   spsc_host i_spsc_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .power_on_i(power_on),
      .reset_req_i(reset_req), .ready_o(ready), .link(lnk));
   // Second device faces the bench so hosts that break the rules can be imitated
   spsc_device i_spsc_device_b (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(lnk_b), .power_state_o(ps_b),
      .internal_reset_n_o(irst_b), .host_pull_o(), .audio_pull_o());
   // Checker watches the second device, the only one that finishes a power-up within the run
   spsc_assertions i_spsc_assertions (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .shutdown_request_low(lnk_b.shutdown_request_low),
      .shutdown_request_low_oe_n(lnk_b.shutdown_request_low_oe_n),
      .io_supply_ok(lnk_b.io_supply_ok), .core_supply_ok(lnk_b.core_supply_ok),
      .host_serial_tx_pin(lnk_b.host_serial_tx_pin), .host_serial_tx_pin_oe_n(lnk_b.host_serial_tx_pin_oe_n),
      .host_request_to_send_pin(lnk_b.host_request_to_send_pin),
      .host_request_to_send_pin_oe_n(lnk_b.host_request_to_send_pin_oe_n),
      .audio_data_out_pin_oe_n(lnk_b.audio_data_out_pin_oe_n),
      .debug_transmit_pin_oe_n(lnk_b.debug_transmit_pin_oe_n));
   // ----------------------------------------
   // Model and reporting
   // ----------------------------------------
   function automatic spsc_pkg::spsc_power_state_t model(input int sd, input int io, input int core);
      if (sd == 0)
         return spsc_pkg::SPSC_PS_SHUTDOWN;
      if (io == 1 && core == 1)
         return spsc_pkg::SPSC_PS_ACTIVE;
      return spsc_pkg::SPSC_PS_NOT_ALLOWED;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pins(input int act, input int b);
      logic [3:0] oe;
      oe = (b == 1) ? {lnk_b.host_serial_tx_pin_oe_n, lnk_b.host_request_to_send_pin_oe_n,
         lnk_b.debug_transmit_pin_oe_n, lnk_b.audio_data_out_pin_oe_n} : {lnk.host_serial_tx_pin_oe_n,
         lnk.host_request_to_send_pin_oe_n, lnk.debug_transmit_pin_oe_n, lnk.audio_data_out_pin_oe_n};
      check({28'h0, oe}, (act == 1) ? 32'h1 : 32'hf);
   endtask
   task final_report;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   // Second device gets a fast slow clock so its 64-edge boot fits the run
   always @(posedge mclk_i)
   begin
      #1;
      if (!reset_n_i)
      begin
         sdiv = 0;
         srise = 0;
         lnk_b.slow_clk = 1'b0;
      end
      else if (sdiv == 7)
      begin
         sdiv = 0;
         lnk_b.slow_clk = ~lnk_b.slow_clk;
         if (lnk_b.slow_clk)
            srise++;
      end
      else
         sdiv++;
   end
   // Tests need about 22k cycles; the real 5 ms host hold is only watched at its start
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 32'h00009c40)
      begin
         failures++;
         final_report;
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      seed = 32'h45d7425c;
      failures = 0;
      compares = 0;
      cycles = 0;
      reset_n_i = 1'b0;
      power_on = 1'b0;
      reset_req = 1'b0;
      lnk_b.shutdown_request_low = 1'b0;
      lnk_b.shutdown_request_low_oe_n = 1'b0;
      lnk_b.io_supply_ok = 1'b0;
      lnk_b.core_supply_ok = 1'b0;
      lnk_b.host_serial_rx_pin = 1'b1;
      lnk_b.host_clear_to_send_pin = 1'b0;
      lnk_b.audio_bit_clock_pin = 1'b0;
      lnk_b.audio_frame_sync_pin = 1'b0;
      lnk_b.audio_data_in_pin = 1'b0;
      repeat (8) @(posedge mclk_i);
      #1 reset_n_i = 1'b1;
      repeat (10) @(posedge mclk_i);
      #1 check(ps, spsc_pkg::SPSC_PS_SHUTDOWN);
      check(irst_n, 1'b0);
      pins(0, 0);
      check(host_pull, spsc_pkg::PULL_UP);
      check(audio_pull, spsc_pkg::PULL_DOWN);
      $display("test shutdown done");
      for (int i = 0; i < 40; i++)
      begin
         v = (i < 16) ? i[3:0] : 4'($random(seed));
         @(posedge mclk_i);
         #1 {lnk_b.core_supply_ok, lnk_b.io_supply_ok, lnk_b.shutdown_request_low_oe_n} = v[3:1];
         lnk_b.shutdown_request_low = v[0];
         exp_ps = model(v[0] & ~v[1], v[2], v[3]);
         repeat (8) @(posedge mclk_i);
         #1 check(ps_b, exp_ps);
         check(lnk_b.host_serial_tx_pin_oe_n, exp_ps != spsc_pkg::SPSC_PS_ACTIVE);
      end
      $display("test power modes done");
      @(posedge mclk_i);
      #1 power_on = 1'b1;
      repeat (20) @(posedge mclk_i);
      #1 check(lnk.io_supply_ok & lnk.core_supply_ok, 1'b1);
      t0 = 0;
      repeat (20000)
      begin
         @(posedge mclk_i);
         #1;
         if (lnk.shutdown_request_low !== 1'b0)
            t0++;
      end
      check(t0, 0);
      check(ps, spsc_pkg::SPSC_PS_SHUTDOWN);
      check(irst_n, 1'b0);
      check(ready, 1'b0);
      pins(0, 0);
      $display("test host hold done");
      // Bench plays a host with a short hold towards the second device
      {lnk_b.core_supply_ok, lnk_b.io_supply_ok, lnk_b.shutdown_request_low_oe_n, lnk_b.shutdown_request_low} = 4'hc;
      repeat (8) @(posedge mclk_i);
      #1 check(ps_b, model(0, 1, 1));
      check(irst_b, 1'b0);
      pins(0, 1);
      lnk_b.shutdown_request_low = 1'b1;
      t0 = cycles;
      repeat (8) @(posedge mclk_i);
      #1 check(ps_b, model(1, 1, 1));
      while (irst_b !== 1'b1)
      begin
         @(posedge mclk_i);
         #1;
      end
      check(lnk_b.slow_clk, 1'b1);
      n0 = srise;
      while (lnk_b.host_request_to_send_pin !== 1'b0)
      begin
         @(posedge mclk_i);
         #1;
      end
      check(srise - n0, spsc_pkg::SLOW_STABLE_CYCLES);
      check(cycles - t0 <= spsc_pkg::READY_MAX_CYC, 1'b1);
      check(ps_b, spsc_pkg::SPSC_PS_ACTIVE);
      check(irst_b, 1'b1);
      check(lnk_b.host_request_to_send_pin_oe_n, 1'b0);
      check(lnk_b.host_serial_tx_pin, 1'b1);
      pins(1, 1);
      $display("test power-up done");
      @(posedge mclk_i);
      #1 lnk_b.shutdown_request_low = 1'b0;
      power_on = 1'b0;
      repeat (10) @(posedge mclk_i);
      #1 check(ps_b, model(0, 1, 1));
      check(irst_b, 1'b0);
      check(lnk_b.host_request_to_send_pin, 1'b1);
      pins(0, 1);
      check(lnk.io_supply_ok, 1'b0);
      $display("test restart done");
      final_report;
   end
endmodule

// >>> testbench/spsc_assertions.sv
`timescale 1ns/1ps
module spsc_assertions (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Link signals
   input wire logic shutdown_request_low,
   input wire logic shutdown_request_low_oe_n,
   input wire logic io_supply_ok,
   input wire logic core_supply_ok,
   input wire logic host_serial_tx_pin,
   input wire logic host_serial_tx_pin_oe_n,
   input wire logic host_request_to_send_pin,
   input wire logic host_request_to_send_pin_oe_n,
   input wire logic audio_data_out_pin_oe_n,
   input wire logic debug_transmit_pin_oe_n
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   localparam longint READY_LIMIT = spsc_pkg::READY_MAX_CYC;
   logic run;
   logic hiz;
   logic [31:0] boot_cnt;
   // A floating shutdown line reads as low, so only a driven high counts as release
   assign run = shutdown_request_low && !shutdown_request_low_oe_n;
   assign hiz = host_serial_tx_pin_oe_n && host_request_to_send_pin_oe_n && debug_transmit_pin_oe_n;
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         boot_cnt <= 32'h0;
      else if (!run)
         boot_cnt <= 32'h0;
      else if (boot_cnt != 32'hffffffff)
         boot_cnt <= boot_cnt + 32'h1;
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // Eight cycles cover the three-flop input sync, the level flop and the state register
   sequence sd_held; !run [*8]; endsequence
   sequence power_lost; (!io_supply_ok || !core_supply_ok) [*8]; endsequence
   sequence act_held; (run && io_supply_ok && core_supply_ok) [*8]; endsequence
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_shutdown_pins_hiz: assert property (sd_held |-> hiz)
      else $error("pins driven during shutdown");
   a_supply_lost_hiz: assert property (power_lost |-> hiz)
      else $error("pins driven with a supply missing");
   a_active_drives: assert property (act_held |-> !host_serial_tx_pin_oe_n && !host_request_to_send_pin_oe_n)
      else $error("active state does not drive tx and rts");
   a_audio_out_hiz: assert property (audio_data_out_pin_oe_n)
      else $error("audio out driven");
   a_tx_drives_high: assert property (!host_serial_tx_pin_oe_n |-> host_serial_tx_pin)
      else $error("tx driven low");
   a_rts_starts_high: assert property ($fell(host_request_to_send_pin_oe_n) |-> host_request_to_send_pin ##1
      host_request_to_send_pin)
      else $error("rts not high at power-up");
   a_rts_low_driven: assert property ($fell(host_request_to_send_pin) |-> !host_request_to_send_pin_oe_n)
      else $error("rts low while undriven");
   a_ready_in_time: assert property (boot_cnt >= READY_LIMIT |-> !host_request_to_send_pin_oe_n
      && !host_request_to_send_pin)
      else $error("rts not low in time");
   a_release_keeps_hiz: assert property ($rose(run) |-> hiz ##1 hiz)
      else $error("pins driven before release is synced");
endmodule
